// [rtl/scc_host.sv]
// smart card side link host with an axi4-lite command port
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"

module scc_host #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // axi4-lite write
  input  wire logic [4:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [4:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // device link
  input  wire scc_pkg::scc_pin_i_t pinIn,
  output var  scc_pkg::scc_pin_o_t pinOut
);
  import scc_pkg::*;

  // divisor writes go by whole byte lanes
  if (DIV_W != 8 && DIV_W != 16) begin : g_chk
    $error("scc_host: DIV_W must be 8 or 16");
  end

  scc_state_t       state_ff;
  logic [3:0]       ctrl_ff;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic [3:0]       bit_ff;
  logic [10:0]      shr_ff;
  logic [7:0]       rxData_ff;
  logic             rxValid_ff;
  logic             parErr_ff;
  logic             overrun_ff;
  logic             brk_ff;
  logic             frmErr_ff;
  logic             sckGen_ff;
  logic             sckPrev_ff;
  logic             tdrPrev_ff;
  logic [2:0]       guard_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [2:0]       meta_ff;
  logic [2:0]       sync_ff;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // the update marker idles low: resetting its stages high would fake an edge
  localparam logic [2:0] SYNC_RST = `SCC_SYNC_RST;
  logic [2:0] rawIn;
  assign rawIn = {pinIn.tdrUpd, pinIn.sckIn, pinIn.ioIn};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_ff[i] <= SYNC_RST[i];
        sync_ff[i] <= SYNC_RST[i];
      end else begin
        meta_ff[i] <= rawIn[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end
  logic ioS;
  logic tdrS;
  assign ioS  = sync_ff[0];
  assign tdrS = sync_ff[2];

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic wrEn, wrCtrl, wrStat, wrTx, txStart, wrOk, rdEn, rdRx;
  logic rxStart, rxDone;
  assign wrEn          = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign s_axi_awready = wrEn;
  assign s_axi_wready  = wrEn;
  assign wrCtrl = wrEn && s_axi_awaddr == `SCC_A_CTRL && s_axi_wstrb[0];
  assign wrStat = wrEn && s_axi_awaddr == `SCC_A_STATUS && s_axi_wstrb[0];
  assign wrTx   = wrEn && s_axi_awaddr == `SCC_A_TXDATA && s_axi_wstrb[0];
  // one direction at a time: no send while the receiver is armed
  // clocked sends are refused with an error response while the overrun, parity or framing error flag is set
  assign txStart = wrTx && state_ff == ST_IDLE && !ctrl_ff[`SCC_C_RXARM]
                && (!ctrl_ff[`SCC_C_SYNC] || !(overrun_ff || parErr_ff || frmErr_ff));
  assign wrOk = (s_axi_awaddr == `SCC_A_CTRL) || (s_axi_awaddr == `SCC_A_DIV)
             || (s_axi_awaddr == `SCC_A_STATUS) || txStart;
  assign rdEn = s_axi_arvalid & ~rvalid_ff;
  assign rdRx = rdEn && s_axi_araddr == `SCC_A_RXDATA;
  assign s_axi_arready = rdEn;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = `SCC_RESP_OKAY;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SCC_RESP_OKAY;
    end else if (wrEn) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wrOk ? `SCC_RESP_OKAY : `SCC_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      `SCC_A_CTRL:   rdMux[3:0] = ctrl_ff;
      `SCC_A_DIV:    rdMux[DIV_W-1:0] = div_ff;
      `SCC_A_RXDATA: rdMux[7:0] = rxData_ff;
      `SCC_A_STATUS: rdMux[5:0] = {frmErr_ff, brk_ff, overrun_ff, parErr_ff,
                                   rxValid_ff, state_ff == ST_TX};
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else if (rdEn) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rdMux;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and divisor registers
  // ----------------------------------------------------------------
  // mode and direction change only by a control write with byte lane 0 enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `SCC_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_ff <= s_axi_wdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= DIV_W'(`SCC_DIV_RST);
    end else if (wrEn && s_axi_awaddr == `SCC_A_DIV) begin
      for (int b = 0; b < DIV_W / 8; b++) begin
        if (s_axi_wstrb[b]) begin
          div_ff[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bit timing and serial clock
  // ----------------------------------------------------------------
  logic asyncM, hostClk, tick, sckSrc, sckRise, tdrRise, cntEv;
  logic [3:0] lastBit;
  assign asyncM  = !ctrl_ff[`SCC_C_SYNC];
  assign hostClk = ctrl_ff[`SCC_C_SYNC] && ctrl_ff[`SCC_C_EXTCLK];
  assign tick    = cnt_ff == '0;
  assign sckSrc  = hostClk ? sckGen_ff : sync_ff[1];
  assign sckRise = sckSrc & ~sckPrev_ff;
  assign tdrRise = tdrS & ~tdrPrev_ff;
  assign cntEv   = asyncM ? tick : sckRise;
  assign lastBit = asyncM ? `SCC_LAST_ASYNC : `SCC_LAST_SYNC;
  assign rxStart = state_ff == ST_IDLE && ctrl_ff[`SCC_C_RXARM]
                && !wrTx && (!asyncM || !ioS);

  // async mode samples mid-bit: the start edge reloads half a period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (rxStart && asyncM) begin
      cnt_ff <= div_ff >> 1;
    end else if (txStart || tick) begin
      cnt_ff <= div_ff - 1'b1;
    end else begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // clock edges held off after a data register update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_ff <= 3'h0;
    end else if (tdrRise) begin
      guard_ff <= `SCC_GUARD_CLK;
    end else if (guard_ff != 3'h0) begin
      guard_ff <= guard_ff - 3'h1;
    end
  end

  // host clock rests high outside frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckGen_ff <= 1'b1;
    end else if (!hostClk || state_ff == ST_IDLE) begin
      sckGen_ff <= 1'b1;
    end else if (tick && guard_ff == 3'h0 && !tdrRise) begin
      sckGen_ff <= ~sckGen_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckPrev_ff <= 1'b1;
      tdrPrev_ff <= 1'b0;
    end else begin
      sckPrev_ff <= sckSrc;
      tdrPrev_ff <= tdrS;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  logic falseStart;
  assign falseStart = asyncM && bit_ff == 4'h0 && ioS;
  assign rxDone = state_ff == ST_RX && cntEv && !falseStart && bit_ff == lastBit;

  // reset drops a frame in flight and returns to idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bit_ff   <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          bit_ff <= 4'h0;
          if (txStart) begin
            state_ff <= ST_TX;
          end else if (rxStart) begin
            state_ff <= ST_RX;
          end
        end
        ST_TX, ST_RX: begin
          if (cntEv) begin
            if (bit_ff == lastBit || (state_ff == ST_RX && falseStart)) begin
              state_ff <= ST_IDLE;
            end else begin
              bit_ff <= bit_ff + 4'h1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  logic txPar;
  assign txPar = ^s_axi_wdata[7:0] ^ ctrl_ff[`SCC_C_ODD];
  // parity framed on every async character
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shr_ff <= 11'h7FF;
    end else if (txStart) begin
      shr_ff <= asyncM ? {1'b1, txPar, s_axi_wdata[7:0], 1'b0}
                       : {3'h7, s_axi_wdata[7:0]};
    end else if (state_ff == ST_TX && cntEv) begin
      shr_ff <= {1'b1, shr_ff[10:1]};
    end else if (state_ff == ST_RX && cntEv) begin
      shr_ff <= {ioS, shr_ff[10:1]};
    end
  end

  // ----------------------------------------------------------------
  // received data and status flags
  // ----------------------------------------------------------------
  logic [10:0] frm;
  logic [7:0]  rxByte;
  logic        parBad, stopBad, brkSeen;
  assign frm     = {ioS, shr_ff[10:1]};
  assign rxByte  = asyncM ? frm[8:1] : frm[10:3];
  assign parBad  = asyncM && (^frm[9:1] ^ ctrl_ff[`SCC_C_ODD]);
  assign stopBad = asyncM && !frm[10];
  assign brkSeen = stopBad && frm[9:1] == 9'h000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxData_ff <= 8'h00;
    end else if (rxDone) begin
      rxData_ff <= rxByte;
    end
  end

  // receive-full marks the end of reception
  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxValid_ff <= 1'b0;
    end else if (rxDone) begin
      rxValid_ff <= 1'b1;
    end else if (rdRx) begin
      rxValid_ff <= 1'b0;
    end
  end

  // error flags cleared by writing ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parErr_ff  <= 1'b0;
      overrun_ff <= 1'b0;
      brk_ff     <= 1'b0;
      frmErr_ff  <= 1'b0;
    end else begin
      parErr_ff  <= (rxDone && parBad) ||
                    (parErr_ff && !(wrStat && s_axi_wdata[`SCC_S_PARERR]));
      overrun_ff <= (rxDone && rxValid_ff) ||
                    (overrun_ff && !(wrStat && s_axi_wdata[`SCC_S_OVERRUN]));
      // break seen as an all-low frame
      brk_ff     <= (rxDone && brkSeen) ||
                    (brk_ff && !(wrStat && s_axi_wdata[`SCC_S_BREAK]));
      frmErr_ff  <= (rxDone && stopBad) ||
                    (frmErr_ff && !(wrStat && s_axi_wdata[`SCC_S_FRMERR]));
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // line released unless sending, so the pulled-up line rests at mark
  assign pinOut.ioOut  = shr_ff[0];
  assign pinOut.ioOe   = state_ff == ST_TX;
  assign pinOut.sckOut = sckGen_ff;
  // device drives the clock unless the host was told to
  assign pinOut.sckOe  = hostClk;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sGuardQuiet;
    $stable(sckGen_ff) [*5];
  endsequence
  sequence sStartBit;
    pinOut.ioOe && !pinOut.ioOut;
  endsequence
  sequence sTxEnd;
    state_ff == ST_TX ##1 state_ff == ST_IDLE;
  endsequence

  a_guard_sck_hold: assert property (tdrRise |=> sGuardQuiet)
    else $error("host clock edge too soon after data update");
  a_sck_release: assert property (!hostClk |-> !pinOut.sckOe ##1 pinOut.sckOut)
    else $error("host drives clock while device owns it");
  a_one_direction: assert property (wrTx && ctrl_ff[`SCC_C_RXARM] && state_ff != ST_TX
    |=> state_ff != ST_TX && s_axi_bresp == `SCC_RESP_ERR)
    else $error("send started while receiver armed");
  a_sync_err_hold: assert property (wrTx && state_ff == ST_IDLE && !asyncM
    && (overrun_ff || parErr_ff || frmErr_ff) |=> state_ff != ST_TX)
    else $error("clocked send started over receive errors");
  a_async_start: assert property (txStart && asyncM |=> sStartBit)
    else $error("async frame did not open with a start bit");
  a_line_release: assert property (sTxEnd |-> pinOut.ioOut && !pinOut.ioOe)
    else $error("line not left at mark after a send");
  a_break_flag: assert property (rxDone && brkSeen |=> brk_ff && frmErr_ff)
    else $error("break frame not flagged");
  a_err_clear: assert property (wrStat && s_axi_wdata[`SCC_S_PARERR]
    && !rxDone |=> !parErr_ff)
    else $error("parity flag not cleared");
  a_div_load: assert property (wrEn && s_axi_awaddr == `SCC_A_DIV
    && &s_axi_wstrb |=> div_ff == $past(s_axi_wdata[DIV_W-1:0]))
    else $error("divisor write lost");
  a_rx_valid: assert property (rxDone |=> rxValid_ff
    && rxData_ff == $past(rxByte))
    else $error("received byte not presented");

endmodule // scc_host
`default_nettype wire

// [rtl/scc_cfg.svh]
// constants of the smart card link host: offsets, fields, timing
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SCC_A_CTRL    5'h00
`define SCC_A_DIV     5'h04
`define SCC_A_TXDATA  5'h08
`define SCC_A_RXDATA  5'h0C
`define SCC_A_STATUS  5'h10
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SCC_C_SYNC    0
`define SCC_C_EXTCLK  1
`define SCC_C_RXARM   2
`define SCC_C_ODD     3
`define SCC_CTRL_RST  4'h0
// synchroniser reset levels {update marker, clock, data}: each at its idle level
`define SCC_SYNC_RST  3'h3
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define SCC_S_TXBUSY  0
`define SCC_S_RXVALID 1
`define SCC_S_PARERR  2
`define SCC_S_OVERRUN 3
`define SCC_S_BREAK   4
`define SCC_S_FRMERR  5
// ----------------------------------------------------------------
// link timing and framing
// ----------------------------------------------------------------
`define SCC_DIV_RST    16'h0010
`define SCC_GUARD_CLK  3'h5
`define SCC_LAST_ASYNC 4'hA
`define SCC_LAST_SYNC  4'h7
`define SCC_RESP_OKAY  2'h0
`define SCC_RESP_ERR   2'h2
`endif

// [rtl/scc_pkg.sv]
// types shared by the smart card link host
`default_nettype none
package scc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} scc_state_t;
  // pins coming from the device
  typedef struct packed {
    logic tdrUpd;
    logic sckIn;
    logic ioIn;
  } scc_pin_i_t;
  // pins going to the device
  typedef struct packed {
    logic ioOut;
    logic ioOe;
    logic sckOut;
    logic sckOe;
  } scc_pin_o_t;
endpackage
`default_nettype wire

// [testbench/scc_card_model.sv]
// remote card model: async and clocked byte exchange on the data line
`timescale 1ns/1ps
`default_nettype none

module scc_card_model (
  // system clock
  input  wire logic                clk,
  // link
  input  wire scc_pkg::scc_pin_o_t pinOut,
  output var  scc_pkg::scc_pin_i_t pinIn
);
  import scc_pkg::*;
  logic devOe  = 1'b0;
  logic devOut = 1'b1;
  logic sck    = 1'b1;
  logic tx_data_reg    = 1'b0;
  logic line;
  // a released line is pulled to mark level
  assign line = pinOut.ioOe ? pinOut.ioOut : (devOe ? devOut : 1'b1);
  always_comb pinIn = '{tdrUpd: tx_data_reg, sckIn: sck, ioIn: line};

  // whole frame: start, nine bits, stop (stop low with all nine bits low sends a break)
  task automatic sendAsync(input int div, input logic [8:0] bits, input logic stopBit);
    logic [10:0] fr;
    fr = {stopBit, bits, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      devOut <= fr[i];
      devOe  <= 1'b1;
      repeat (div - 1) @(posedge clk);
    end
    @(posedge clk);
    devOe <= 1'b0;
  endtask

  // samples mid-bit after the start edge; got[9] is the stop bit
  task automatic catchAsync(input int div, output logic [9:0] got);
    @(posedge clk iff (pinOut.ioOe === 1'b1 && pinOut.ioOut === 1'b0));
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (div) @(posedge clk);
      got[i] = line;
    end
  endtask

  // clocked frame on the card's own clock, 160 ns a bit; clock rests high outside
  task automatic sendSync(input logic [7:0] d);
    @(posedge clk);
    devOe <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sck    <= 1'b0;
      devOut <= d[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
    end
    devOe <= 1'b0;
  endtask

  task automatic catchSync(output logic [7:0] got);
    for (int i = 0; i < 8; i++) begin
      @(posedge pinOut.sckOut iff pinOut.sckOe === 1'b1);
      got[i] = pinOut.ioOut;
    end
  endtask

  task automatic pulseTdr();
    @(posedge clk);
    tx_data_reg <= 1'b1;
    repeat (4) @(posedge clk);
    tx_data_reg <= 1'b0;
  endtask
endmodule // scc_card_model

`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the card link host: registers and link frames
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"

module testbench;
  import scc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  awAddr = '0, arAddr = '0;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [31:0] wData = '0, rData, rd;
  logic [3:0]  wStrb = '0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp;
  logic [9:0]  got;
  logic [7:0]  gs;
  int          badCount = 0;
  int          compares = 0;
  int          n;
  scc_pin_i_t  pinIn;
  scc_pin_o_t  pinOut;
  always #10 clk = ~clk;

  scc_host dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pinIn(pinIn), .pinOut(pinOut));
  scc_card_model dev (.clk(clk), .pinOut(pinOut), .pinIn(pinIn));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // both write channels offered together; er is the expected response
  task automatic axW(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    do @(posedge clk); while (!(awReady === 1'b1 && wReady === 1'b1));
    awValid <= 1'b0;
    wValid <= 1'b0;
    bReady <= 1'b1;
    do @(posedge clk); while (bValid !== 1'b1);
    chk("bresp", 32'(bResp), 32'(er));
    bReady <= 1'b0;
  endtask

  task automatic axR(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    rReady <= 1'b1;
    do @(posedge clk); while (rValid !== 1'b1);
    d = rData;
    chk("rresp", 32'(rResp), 32'(`SCC_RESP_OKAY));
    rReady <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v,
                     input string nm);
    axR(a, rd);
    chk(nm, rd & m, v);
  endtask

  task automatic waitStat(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 600; i++) begin
      axR(`SCC_A_STATUS, rd);
      if ((rd & m) === v) break;
    end
    chk("status wait", rd & m, v);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle pins", 32'(pinOut), 32'h0000_000A);
    rdc(`SCC_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl reset");
    rdc(`SCC_A_DIV, 32'h0000_FFFF, 32'(`SCC_DIV_RST), "div reset");
    rdc(`SCC_A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, "status reset");
    rdc(5'h14, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    axW(5'h18, 32'h0000_0001, 4'hF, `SCC_RESP_ERR);
    axW(`SCC_A_RXDATA, 32'h0000_0001, 4'hF, `SCC_RESP_ERR);
    axW(`SCC_A_CTRL, 32'h0000_0004, 4'h0, `SCC_RESP_OKAY);
    rdc(`SCC_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "lane off");
    // even then odd parity send, busy refusal in mid frame
    for (int m = 0; m < 2; m++) begin
      axW(`SCC_A_CTRL, 32'(m << `SCC_C_ODD), 4'hF, `SCC_RESP_OKAY);
      fork
        dev.catchAsync(16, got);
        begin
          axW(`SCC_A_TXDATA, 32'h0000_00A5, 4'hF, `SCC_RESP_OKAY);
          rdc(`SCC_A_STATUS, 32'h0000_0001, 32'h0000_0001, "txbusy");
          axW(`SCC_A_TXDATA, 32'h0000_005A, 4'hF, `SCC_RESP_ERR);
        end
      join
      chk("tx frame", 32'(got), 32'({1'b1, (^8'hA5) ^ m[0], 8'hA5}));
      waitStat(32'h0000_0001, 32'h0000_0000);
      chk("tx released", 32'({pinOut.ioOe, pinOut.ioOut}), 32'h0000_0001);
    end
    // reset in mid frame: line back at mark, link state cleared
    axW(`SCC_A_TXDATA, 32'h0000_00C3, 4'hF, `SCC_RESP_OKAY);
    repeat (40) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("cut pins", 32'(pinOut), 32'h0000_000A);
    rdc(`SCC_A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, "cut status");
    rdc(`SCC_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "cut ctrl");
    // receive direction, errors and flag clearing
    axW(`SCC_A_CTRL, 32'h0000_0004, 4'hF, `SCC_RESP_OKAY);
    axW(`SCC_A_TXDATA, 32'h0000_0011, 4'hF, `SCC_RESP_ERR);
    dev.sendAsync(16, {^8'h3C, 8'h3C}, 1'b1);
    waitStat(32'h0000_0002, 32'h0000_0002);
    rdc(`SCC_A_RXDATA, 32'h0000_00FF, 32'h0000_003C, "rx data");
    rdc(`SCC_A_STATUS, 32'h0000_003E, 32'h0000_0000, "rx clear");
    dev.sendAsync(16, {~^8'h55, 8'h55}, 1'b1);
    waitStat(32'h0000_0002, 32'h0000_0002);
    rdc(`SCC_A_STATUS, 32'h0000_0004, 32'h0000_0004, "parity err");
    axW(`SCC_A_STATUS, 32'h0000_0000, 4'hF, `SCC_RESP_OKAY);
    rdc(`SCC_A_STATUS, 32'h0000_0004, 32'h0000_0004, "zero write");
    axW(`SCC_A_STATUS, 32'h0000_0004, 4'hF, `SCC_RESP_OKAY);
    rdc(`SCC_A_STATUS, 32'h0000_0004, 32'h0000_0000, "flag clear");
    dev.sendAsync(16, {^8'h11, 8'h11}, 1'b1);
    repeat (4) @(posedge clk);
    rdc(`SCC_A_STATUS, 32'h0000_0008, 32'h0000_0008, "overrun");
    axR(`SCC_A_RXDATA, rd);
    dev.sendAsync(16, 9'h000, 1'b0);
    repeat (20) @(posedge clk);
    rdc(`SCC_A_STATUS, 32'h0000_0030, 32'h0000_0030, "break");
    axR(`SCC_A_RXDATA, rd);
    axW(`SCC_A_CTRL, 32'h0000_000C, 4'hF, `SCC_RESP_OKAY);
    dev.sendAsync(16, {~^8'h3C, 8'h3C}, 1'b1);
    waitStat(32'h0000_0002, 32'h0000_0002);
    rdc(`SCC_A_STATUS, 32'h0000_0004, 32'h0000_0000, "odd parity");
    rdc(`SCC_A_RXDATA, 32'h0000_00FF, 32'h0000_003C, "odd rx data");
    axW(`SCC_A_CTRL, 32'h0000_0000, 4'hF, `SCC_RESP_OKAY);
    rdc(`SCC_A_STATUS, 32'h0000_0038, 32'h0000_0038, "flags kept");
    // clocked send held back by error flags, then sent on host clock
    axW(`SCC_A_CTRL, 32'h0000_0003, 4'hF, `SCC_RESP_OKAY);
    chk("clock out", 32'(pinOut.sckOe), 32'h0000_0001);
    axW(`SCC_A_TXDATA, 32'h0000_0096, 4'hF, `SCC_RESP_ERR);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (pinOut.ioOe !== 1'b0) n++;
    end
    chk("tx blocked", 32'(n), 32'h0000_0000);
    fork
      dev.catchSync(gs);
      begin
        axW(`SCC_A_STATUS, 32'h0000_003C, 4'hF, `SCC_RESP_OKAY);
        repeat (10) @(posedge clk);
        rdc(`SCC_A_STATUS, 32'h0000_003C, 32'h0000_0000, "flags cleared");
        axW(`SCC_A_TXDATA, 32'h0000_0096, 4'hF, `SCC_RESP_OKAY);
        // marker pulse while the host clock runs
        dev.pulseTdr();
      end
    join
    chk("sync tx", 32'(gs), 32'h0000_0096);
    // clocked receive on the card's own clock
    waitStat(32'h0000_0001, 32'h0000_0000);
    axW(`SCC_A_CTRL, 32'h0000_0005, 4'hF, `SCC_RESP_OKAY);
    dev.sendSync(8'hC3);
    waitStat(32'h0000_0002, 32'h0000_0002);
    rdc(`SCC_A_RXDATA, 32'h0000_00FF, 32'h0000_00C3, "sync rx");
    summarize();
  end

  // runs well past the longest expected test time
  initial begin
    #1_000_000;
    badCount++;
    summarize();
  end
endmodule // testbench

`default_nettype wire
